// ### tb/lgtr_partner.sv
// Purpose: Model of the function blocks that feed the gates and the relay.
// Assumes: Requests from the bench are taken on the rising edge of clk.
// Notes:   One scan of delay, as a neighbouring block's own output would add.
`timescale 1ns/1ps

module lgtr_partner (
    input  wire logic                     clk,
    input  wire lgtr_pkg::lgtr_gate_in_t  and_req,
    input  wire lgtr_pkg::lgtr_gate_in_t  xor_req,
    input  wire lgtr_pkg::lgtr_relay_in_t rly_req,
    output lgtr_pkg::lgtr_gate_in_t       and_in,
    output lgtr_pkg::lgtr_gate_in_t       xor_in,
    output lgtr_pkg::lgtr_relay_in_t      rly_in
);
    // Masks carry two or more connected inputs from the bench, except the all-zero requests set before the first test.
    always @(posedge clk) begin
        and_in <= and_req;
        xor_in <= xor_req;
        rly_in <= rly_req;
    end
endmodule

// ### tb/lgtr_top_tb_top.sv
// Purpose: Self-checking bench for the gates, constants and toggle relay.
// Assumes: Results are registered, one scan after the design samples them.
// Notes:   Each request is held three scans so every level is sampled.
`timescale 1ns/1ps

module lgtr_top_tb_top;
    logic                     clk;
    logic                     arst_n;
    lgtr_pkg::lgtr_gate_in_t  and_req;
    lgtr_pkg::lgtr_gate_in_t  xor_req;
    lgtr_pkg::lgtr_relay_in_t rly_req;
    lgtr_pkg::lgtr_gate_in_t  and_in;
    lgtr_pkg::lgtr_gate_in_t  xor_in;
    lgtr_pkg::lgtr_relay_in_t rly_in;
    logic                     conj;
    logic                     par;
    logic                     one;
    logic                     zero;
    logic                     rly;
    int                       n_fail;
    int                       n_compared;

    lgtr_partner i_lgtr_partner (.clk(clk), .and_req(and_req), .xor_req(xor_req),
        .rly_req(rly_req), .and_in(and_in), .xor_in(xor_in), .rly_in(rly_in));
    lgtr_top i_lgtr_top (.CLK(clk), .ARST_N(arst_n), .AND_IN(and_in), .XOR_IN(xor_in),
        .RELAY_IN(rly_in), .CONJUNCTION_OUTPUT(conj), .PARITY_OUTPUT(par),
        .CONSTANT_ONE_OUTPUT(one), .CONSTANT_ZERO_OUTPUT(zero), .TOGGLE_RELAY_OUTPUT(rly));

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compared=%0d mismatches=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic apply(logic [7:0] a, logic [7:0] x, logic [2:0] r);
        @(posedge clk);
        and_req <= a;
        xor_req <= x;
        rly_req <= r;
        repeat (2) @(posedge clk);
        #1;
        chk({one, zero}, 8'h2);
    endtask

    // Relay request {trigger, set, clear} and the relay level expected after it.
    task automatic relay_step(logic [2:0] r, logic exp);
        apply(8'h30, 8'h30, r);
        chk(rly, exp);
    endtask

    task automatic test_gates();
        logic [3:0] m;
        logic [3:0] lv;
        for (int k = 0; k < 4; k++) begin
            m = (k == 0) ? 4'h3 : (k == 1) ? 4'h7 : (k == 2) ? 4'hf : 4'ha;
            for (int v = 0; v < 16; v++) begin
                lv = v[3:0];
                apply({m, lv}, {m, lv}, 3'h0);
                chk(conj, (lv & m) == m);
                chk(par, $countones(lv & m) % 2 == 1);
            end
        end
    endtask

    task automatic test_toggle();
        relay_step(3'h4, 1'h1);
        relay_step(3'h0, 1'h1);
        relay_step(3'h4, 1'h0);
        relay_step(3'h4, 1'h0);
        relay_step(3'h0, 1'h0);
    endtask

    // A trigger edge under set is used up, so dropping set must not toggle.
    task automatic test_set_clear();
        relay_step(3'h6, 1'h1);
        relay_step(3'h4, 1'h1);
        relay_step(3'h0, 1'h1);
        relay_step(3'h1, 1'h0);
        relay_step(3'h2, 1'h1);
        relay_step(3'h3, 1'h0);
        relay_step(3'h2, 1'h1);
        relay_step(3'h7, 1'h0);
        relay_step(3'h0, 1'h0);
    endtask

    // Trigger is held high across the reset, so the cleared history makes it an edge.
    task automatic test_reset();
        relay_step(3'h2, 1'h1);
        @(posedge clk);
        arst_n  <= 1'h0;
        rly_req <= 3'h4;
        #1;
        chk({rly, one, zero}, 8'h2);
        @(posedge clk);
        arst_n <= 1'h1;
        relay_step(3'h4, 1'h1);
        relay_step(3'h1, 1'h0);
    endtask

    initial begin
        arst_n = 1'h0;
        and_req = '0;
        xor_req = '0;
        rly_req = '0;
        n_fail = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'h1;
        #1;
        chk({rly, one, zero}, 8'h2);
        test_gates();
        test_toggle();
        test_set_clear();
        test_reset();
        report_and_stop();
    end

    // About 260 scans are needed; some nine times that cuts a hang short.
    initial begin
        #12000;
        n_fail++;
        report_and_stop();
    end
endmodule

// ### verilog/lgtr_pkg.sv
// Purpose: Shared types and constants for the logic gate and toggle relay block.
// Assumes: One scan of the control program equals one rising edge of CLK.
// Notes:   The list below gives the behaviour that the block keeps.
// Function
// - The AND output is 1 only when every connected input is 1, for two to four inputs.
// - The XOR output is 1 exactly when an odd number of connected inputs are 1.
// - The constant-one output stays at 1 while the controller runs.
// - The constant-zero output stays at 0 at all times.
// - Each rising edge of trigger inverts the relay output while set and clear are low.
// - While set is 1 and clear is not, the relay output is 1 whatever the trigger does.
// - A rising edge on clear forces the relay output to 0.
// - While clear is 1 the relay output is 0, so clear wins over set and trigger.
// - With all three relay inputs at 0 the relay output keeps its last value.

package lgtr_pkg;

    // ------------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------------
    localparam int   GATE_INPUTS     = 4;
    localparam logic RELAY_RESET_VAL = 1'h0;
    localparam logic HIST_RESET_VAL  = 1'h0;
    localparam logic GATE_RESET_VAL  = 1'h0;
    localparam logic ONE_RESET_VAL   = 1'h1;
    localparam logic ZERO_VAL        = 1'h0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [GATE_INPUTS-1:0] connected;
        logic                   gate_input_4;
        logic                   gate_input_3;
        logic                   gate_input_2;
        logic                   gate_input_1;
    } lgtr_gate_in_t;

    typedef struct packed {
        logic trigger;
        logic set;
        logic clear;
    } lgtr_relay_in_t;

    typedef struct packed {
        logic conjunction;
        logic parity;
        logic constant_one;
        logic constant_zero;
        logic relay;
        logic trig_hist;
        logic set_hist;
        logic clear_hist;
    } lgtr_state_t;

endpackage

// ### verilog/lgtr_top.sv
// Purpose: AND, XOR, constant sources and an impulse toggle relay, one scan per clock.
// Assumes: All inputs are synchronous to CLK and come from other function blocks.
// Notes:   Every output is registered, so results appear one scan after their inputs.
`timescale 1ns/1ps

module lgtr_top (
    input  wire logic                     CLK,
    input  wire logic                     ARST_N,
    input  wire lgtr_pkg::lgtr_gate_in_t  AND_IN,
    input  wire lgtr_pkg::lgtr_gate_in_t  XOR_IN,
    input  wire lgtr_pkg::lgtr_relay_in_t RELAY_IN,
    output logic                          CONJUNCTION_OUTPUT,
    output logic                          PARITY_OUTPUT,
    output logic                          CONSTANT_ONE_OUTPUT,
    output logic                          CONSTANT_ZERO_OUTPUT,
    output logic                          TOGGLE_RELAY_OUTPUT
);

    // ------------------------------------------------------------------
    // Gate input masking
    // ------------------------------------------------------------------
    logic [lgtr_pkg::GATE_INPUTS-1:0] and_level;
    logic [lgtr_pkg::GATE_INPUTS-1:0] xor_level;
    logic [lgtr_pkg::GATE_INPUTS-1:0] and_eff;
    logic [lgtr_pkg::GATE_INPUTS-1:0] xor_eff;

    assign and_level = {AND_IN.gate_input_4, AND_IN.gate_input_3,
                        AND_IN.gate_input_2, AND_IN.gate_input_1};
    assign xor_level = {XOR_IN.gate_input_4, XOR_IN.gate_input_3,
                        XOR_IN.gate_input_2, XOR_IN.gate_input_1};

    // An open AND input acts as 1 and an open XOR input as 0, so neither disturbs the result.
    genvar gi;
    generate
        for (gi = 0; gi < lgtr_pkg::GATE_INPUTS; gi++) begin : g_mask
            assign and_eff[gi] = and_level[gi] | ~AND_IN.connected[gi];
            assign xor_eff[gi] = xor_level[gi] & XOR_IN.connected[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // State update
    // ------------------------------------------------------------------
    lgtr_pkg::lgtr_state_t state_q;
    lgtr_pkg::lgtr_state_t state_d;
    logic                  trig_rise;
    logic                  clear_rise;

    // Edges compare this scan's level with the level stored one scan earlier.
    assign trig_rise  = RELAY_IN.trigger & ~state_q.trig_hist;
    assign clear_rise = RELAY_IN.clear & ~state_q.clear_hist;

    always_comb begin
        state_d               = state_q;
        state_d.conjunction   = &and_eff;
        state_d.parity        = ^xor_eff;
        state_d.constant_one  = lgtr_pkg::ONE_RESET_VAL;
        state_d.constant_zero = lgtr_pkg::ZERO_VAL;
        state_d.trig_hist     = RELAY_IN.trigger;
        state_d.set_hist      = RELAY_IN.set;
        state_d.clear_hist    = RELAY_IN.clear;
        // Clear is checked first because its level dominates; its edge is covered by it.
        if (RELAY_IN.clear || clear_rise) begin
            state_d.relay = 1'h0;
        end else if (RELAY_IN.set) begin
            state_d.relay = 1'h1;
        end else if (trig_rise) begin
            state_d.relay = ~state_q.relay;
        end else begin
            state_d.relay = state_q.relay;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q.conjunction   <= lgtr_pkg::GATE_RESET_VAL;
            state_q.parity        <= lgtr_pkg::GATE_RESET_VAL;
            state_q.constant_one  <= lgtr_pkg::ONE_RESET_VAL;
            state_q.constant_zero <= lgtr_pkg::ZERO_VAL;
            state_q.relay         <= lgtr_pkg::RELAY_RESET_VAL;
            state_q.trig_hist     <= lgtr_pkg::HIST_RESET_VAL;
            state_q.set_hist      <= lgtr_pkg::HIST_RESET_VAL;
            state_q.clear_hist    <= lgtr_pkg::HIST_RESET_VAL;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign CONJUNCTION_OUTPUT   = state_q.conjunction;
    assign PARITY_OUTPUT        = state_q.parity;
    assign CONSTANT_ONE_OUTPUT  = state_q.constant_one;
    assign CONSTANT_ZERO_OUTPUT = state_q.constant_zero;
    assign TOGGLE_RELAY_OUTPUT  = state_q.relay;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // The first sampled edge after release still shows reset values, so checks that look
    // back one scan wait for this flag.
    logic live_q;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            live_q <= 1'h0;
        end else begin
            live_q <= 1'h1;
        end
    end

    a_and_all_high:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        live_q |-> (CONJUNCTION_OUTPUT ==
            ((($past(and_level) | ~$past(AND_IN.connected)) == 4'hf) ? 1'h1 : 1'h0)))
    else $error("AND output does not match the connected inputs");

    a_and_any_low:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        ((and_level & AND_IN.connected) != AND_IN.connected) |=> !CONJUNCTION_OUTPUT)
    else $error("AND output high although a connected input was low");

    a_xor_odd_count:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        live_q |-> (PARITY_OUTPUT == ($countones($past(xor_eff)) % 2 == 1)))
    else $error("XOR output does not follow the odd count");

    a_xor_four_high:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (xor_level == 4'hf && XOR_IN.connected == 4'hf) |=> !PARITY_OUTPUT)
    else $error("XOR output high with four inputs high");

    a_const_one_held:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        CONSTANT_ONE_OUTPUT)
    else $error("Constant one output dropped");

    a_const_zero_held:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        !CONSTANT_ZERO_OUTPUT)
    else $error("Constant zero output rose");

    a_relay_toggles:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (live_q && RELAY_IN.trigger && !$past(RELAY_IN.trigger)
            && !RELAY_IN.set && !RELAY_IN.clear)
        |=> (TOGGLE_RELAY_OUTPUT != $past(TOGGLE_RELAY_OUTPUT)))
    else $error("Relay did not invert on a trigger edge");

    a_relay_set_wins:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (RELAY_IN.set && !RELAY_IN.clear) [*2] |=> TOGGLE_RELAY_OUTPUT [*1])
    else $error("Relay not high while set is held");

    a_relay_clear_edge:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (live_q && $rose(RELAY_IN.clear)) |=> !TOGGLE_RELAY_OUTPUT)
    else $error("Relay not cleared by a clear edge");

    a_relay_clear_dom:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (RELAY_IN.clear && RELAY_IN.set && RELAY_IN.trigger) |=> !TOGGLE_RELAY_OUTPUT)
    else $error("Relay high while clear is high");

    a_relay_holds:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (live_q && !RELAY_IN.trigger && !RELAY_IN.set && !RELAY_IN.clear)
        |=> $stable(TOGGLE_RELAY_OUTPUT))
    else $error("Relay changed with all inputs low");

    a_relay_reset_zero:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        !live_q |-> (!TOGGLE_RELAY_OUTPUT && !state_q.trig_hist && !state_q.clear_hist))
    else $error("Relay state not zero after reset");

    a_and_four_high:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (live_q && and_level == 4'hf)
        |=> CONJUNCTION_OUTPUT)
    else $error("AND output low with four inputs high");

    a_xor_one_high:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (live_q && $countones(xor_level & XOR_IN.connected) == 1)
        |=> PARITY_OUTPUT)
    else $error("XOR output low with one connected input high");

    a_xor_even_low:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (live_q && $countones(xor_level & XOR_IN.connected) == 2)
        |=> !PARITY_OUTPUT)
    else $error("XOR output high with two connected inputs high");

    a_relay_set_level:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (live_q && RELAY_IN.set && !RELAY_IN.clear)
        |=> TOGGLE_RELAY_OUTPUT)
    else $error("Relay low one scan after set was seen");

    a_relay_clear_level:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (live_q && RELAY_IN.clear)
        |=> !TOGGLE_RELAY_OUTPUT)
    else $error("Relay high one scan after clear was seen");

    a_relay_off_on:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (live_q && RELAY_IN.trigger && !$past(RELAY_IN.trigger) && !RELAY_IN.set
            && !RELAY_IN.clear && !TOGGLE_RELAY_OUTPUT)
        |=> TOGGLE_RELAY_OUTPUT)
    else $error("Relay did not turn on at a trigger edge");

    a_relay_held_trig:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        (live_q && RELAY_IN.trigger && $past(RELAY_IN.trigger) && !RELAY_IN.set
            && !RELAY_IN.clear)
        |=> $stable(TOGGLE_RELAY_OUTPUT))
    else $error("Relay changed while trigger stayed high");

    a_hist_tracks:
    assert property (@(posedge CLK) disable iff (!ARST_N)
        live_q |-> (state_q.trig_hist == $past(RELAY_IN.trigger)
            && state_q.clear_hist == $past(RELAY_IN.clear)))
    else $error("Edge history does not hold the previous scan");

endmodule
